// ---- logic/mbx_exec.sv ----
`timescale 1ns/10ps
module mbx_exec (
  input wire logic ref_clk_in, // core clock
  input wire logic rst_b_in, // sync reset, active low
  input wire logic start_in, // request valid
  input wire mbx_pkg::mbx_req_t req_in, // decoded instruction and operands
  output logic busy_out, // instruction still executing
  output logic done_out, // one-cycle pulse, result complete
  output mbx_pkg::mbx_res_t res_out // result, held until next request
);
  import mbx_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  // subtract flags shared by the three compares
  function automatic logic [7:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic keep_z,
                                           input logic [7:0] old);
    logic [7:0] r;
    logic [7:0] f;
    r = a - b - {7'h00, cin};
    f = old;
    f[STAT_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    f[STAT_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    f[STAT_N] = r[7];
    f[STAT_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    // carry form only keeps zero if it was already set, for multi-byte chains
    f[STAT_Z] = (r == 8'h00) & (~keep_z | old[STAT_Z]);
    f[STAT_S] = f[STAT_N] ^ f[STAT_V];
    return f;
  endfunction

  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
                                                 input logic [6:0] k);
    return pc + {{(PC_W-7){k[6]}}, k} + PC_STEP;
  endfunction

  // ************************************************************
  // next result
  // ************************************************************
  logic take;
  logic [1:0] next_cycles;
  mbx_res_t next_res;
  logic [15:0] raw_prod;
  logic [16:0] mixed_prod;
  logic skip;
  logic taken;
  logic is_skip;
  logic is_branch;
  logic [7:0] st;

  assign take = start_in & ~busy_out;
  assign st = req_in.status_register;
  assign mixed_prod = 17'($signed({req_in.rd_val[7], req_in.rd_val}) *
                          $signed({1'b0, req_in.rr_val}));

  always_comb
  begin
    raw_prod = 16'h0000;
    skip = 1'b0;
    taken = 1'b0;
    is_skip = 1'b0;
    is_branch = 1'b0;
    next_cycles = CYC_ONE;
    next_res.pc = req_in.pc + PC_STEP;
    next_res.product = res_out.product;
    next_res.product_we = 1'b0;
    next_res.status_register = st;
    next_res.push_ret = 1'b0;
    next_res.ret_addr = req_in.pc + PC_STEP;
    unique case (req_in.op)
      MBX_SIGNED_MULTIPLY, MBX_FRACTIONAL_MULTIPLY_SIGNED:
      begin
        raw_prod = 16'($signed(req_in.rd_val) * $signed(req_in.rr_val));
      end
      MBX_SIGNED_UNSIGNED_MULTIPLY, MBX_FRACTIONAL_MULTIPLY_MIXED:
      begin
        raw_prod = mixed_prod[15:0];
      end
      MBX_FRACTIONAL_MULTIPLY_UNSIGNED:
      begin
        raw_prod = 16'(req_in.rd_val * req_in.rr_val);
      end
      MBX_INDIRECT_JUMP:
      begin
        next_res.pc = req_in.z_ptr;
        next_cycles = CYC_TWO;
      end
      MBX_INDIRECT_CALL:
      begin
        next_res.pc = req_in.z_ptr;
        next_res.push_ret = 1'b1;
        next_cycles = CYC_THREE;
      end
      MBX_COMPARE_SKIP_EQUAL:
      begin
        is_skip = 1'b1;
        skip = req_in.rd_val == req_in.rr_val;
      end
      MBX_COMPARE_REGS:
      begin
        next_res.status_register = sub_flags(req_in.rd_val, req_in.rr_val, 1'b0, 1'b0,
                                             st);
      end
      MBX_COMPARE_WITH_CARRY:
      begin
        next_res.status_register = sub_flags(req_in.rd_val, req_in.rr_val, st[STAT_C],
                                             1'b1, st);
      end
      MBX_COMPARE_IMMEDIATE:
      begin
        next_res.status_register = sub_flags(req_in.rd_val, req_in.imm_val, 1'b0, 1'b0,
                                             st);
      end
      MBX_SKIP_REG_BIT_CLEAR, MBX_SKIP_REG_BIT_SET:
      begin
        is_skip = 1'b1;
        skip = req_in.rr_val[req_in.bit_sel] ==
               (req_in.op == MBX_SKIP_REG_BIT_SET);
      end
      MBX_SKIP_IO_BIT_CLEAR, MBX_SKIP_IO_BIT_SET:
      begin
        is_skip = 1'b1;
        skip = req_in.io_val[req_in.bit_sel] ==
               (req_in.op == MBX_SKIP_IO_BIT_SET);
      end
      MBX_BRANCH_FLAG_SET:
      begin
        is_branch = 1'b1;
        taken = st[req_in.bit_sel];
      end
      MBX_BRANCH_FLAG_CLEAR:
      begin
        is_branch = 1'b1;
        taken = ~st[req_in.bit_sel];
      end
      MBX_BRANCH_EQUAL, MBX_BRANCH_NOT_EQUAL:
      begin
        is_branch = 1'b1;
        taken = st[STAT_Z] == (req_in.op == MBX_BRANCH_EQUAL);
      end
      MBX_BRANCH_CARRY_SET, MBX_BRANCH_CARRY_CLEAR:
      begin
        is_branch = 1'b1;
        taken = st[STAT_C] == (req_in.op == MBX_BRANCH_CARRY_SET);
      end
      MBX_BRANCH_SAME_HIGHER, MBX_BRANCH_LOWER:
      begin
        is_branch = 1'b1;
        taken = st[STAT_C] == (req_in.op == MBX_BRANCH_LOWER);
      end
      MBX_BRANCH_MINUS, MBX_BRANCH_PLUS:
      begin
        is_branch = 1'b1;
        taken = st[STAT_N] == (req_in.op == MBX_BRANCH_MINUS);
      end
      MBX_BRANCH_SIGNED_GE, MBX_BRANCH_SIGNED_LT:
      begin
        is_branch = 1'b1;
        taken = (st[STAT_N] ^ st[STAT_V]) == (req_in.op == MBX_BRANCH_SIGNED_LT);
      end
      MBX_BRANCH_HALF_CARRY_SET, MBX_BRANCH_HALF_CARRY_CLEAR:
      begin
        is_branch = 1'b1;
        taken = st[STAT_H] == (req_in.op == MBX_BRANCH_HALF_CARRY_SET);
      end
      MBX_BRANCH_TBIT_SET, MBX_BRANCH_TBIT_CLEAR:
      begin
        is_branch = 1'b1;
        taken = st[STAT_T] == (req_in.op == MBX_BRANCH_TBIT_SET);
      end
      MBX_BRANCH_OVERFLOW_SET:
      begin
        is_branch = 1'b1;
        // the opcode field has room for one overflow op; its clear form goes as
        // branch_flag_clear with the overflow bit selected
        taken = st[STAT_V];
      end
    endcase

    if (req_in.op inside {MBX_SIGNED_MULTIPLY, MBX_SIGNED_UNSIGNED_MULTIPLY,
                          MBX_FRACTIONAL_MULTIPLY_UNSIGNED, MBX_FRACTIONAL_MULTIPLY_SIGNED,
                          MBX_FRACTIONAL_MULTIPLY_MIXED})
    begin
      next_res.product_we = 1'b1;
      next_cycles = CYC_TWO;
      // carry is the top bit before any shift, as fractional users expect
      next_res.status_register[STAT_C] = raw_prod[15];
      if (req_in.op inside {MBX_SIGNED_MULTIPLY, MBX_SIGNED_UNSIGNED_MULTIPLY})
      begin
        next_res.product = raw_prod;
      end
      else
      begin
        next_res.product = {raw_prod[14:0], 1'b0};
      end
      next_res.status_register[STAT_Z] = next_res.product == 16'h0000;
    end

    if (is_skip && skip)
    begin
      if (req_in.next_two_word)
      begin
        next_res.pc = req_in.pc + SKIP_TWO_WORD;
        next_cycles = CYC_THREE;
      end
      else
      begin
        next_res.pc = req_in.pc + SKIP_ONE_WORD;
        next_cycles = CYC_TWO;
      end
    end

    if (is_branch && taken)
    begin
      next_res.pc = rel_target(req_in.pc, req_in.offset);
      next_cycles = CYC_TWO;
    end
  end

  // ************************************************************
  // result register
  // ************************************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      res_out <= '{pc: PC_RESET, product: PRODUCT_RESET, product_we: 1'b0,
                   status_register: STATUS_RESET, push_ret: 1'b0, ret_addr: PC_RESET};
    end
    else if (take)
    begin
      res_out <= next_res;
    end
  end

  // ************************************************************
  // cycle timing
  // ************************************************************
  logic [1:0] count;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      count <= COUNT_RESET;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else if (take)
    begin
      count <= next_cycles - CYC_ONE;
      busy_out <= next_cycles != CYC_ONE;
      done_out <= next_cycles == CYC_ONE;
    end
    else if (busy_out)
    begin
      count <= count - CYC_ONE;
      busy_out <= count != CYC_ONE;
      done_out <= count == CYC_ONE;
    end
    else
    begin
      done_out <= 1'b0;
    end
  end

endmodule

// ---- common/mbx_pkg.sv ----
package mbx_pkg;

  // ************************************************************
  // widths and status bit positions
  // ************************************************************
  localparam int PC_W = 16;
  localparam int STAT_C = 0;
  localparam int STAT_Z = 1;
  localparam int STAT_N = 2;
  localparam int STAT_V = 3;
  localparam int STAT_S = 4;
  localparam int STAT_H = 5;
  localparam int STAT_T = 6;
  localparam int STAT_I = 7;

  // ************************************************************
  // cycle counts and pc steps
  // ************************************************************
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
  localparam logic [PC_W-1:0] SKIP_ONE_WORD = 16'h0002;
  localparam logic [PC_W-1:0] SKIP_TWO_WORD = 16'h0003;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PRODUCT_RESET = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] COUNT_RESET = 2'h0;

  typedef enum logic [4:0] {
    MBX_SIGNED_MULTIPLY,
    MBX_SIGNED_UNSIGNED_MULTIPLY,
    MBX_FRACTIONAL_MULTIPLY_UNSIGNED,
    MBX_FRACTIONAL_MULTIPLY_SIGNED,
    MBX_FRACTIONAL_MULTIPLY_MIXED,
    MBX_INDIRECT_JUMP,
    MBX_INDIRECT_CALL,
    MBX_COMPARE_SKIP_EQUAL,
    MBX_COMPARE_REGS,
    MBX_COMPARE_WITH_CARRY,
    MBX_COMPARE_IMMEDIATE,
    MBX_SKIP_REG_BIT_CLEAR,
    MBX_SKIP_REG_BIT_SET,
    MBX_SKIP_IO_BIT_CLEAR,
    MBX_SKIP_IO_BIT_SET,
    MBX_BRANCH_FLAG_SET,
    MBX_BRANCH_FLAG_CLEAR,
    MBX_BRANCH_EQUAL,
    MBX_BRANCH_NOT_EQUAL,
    MBX_BRANCH_CARRY_SET,
    MBX_BRANCH_CARRY_CLEAR,
    MBX_BRANCH_SAME_HIGHER,
    MBX_BRANCH_LOWER,
    MBX_BRANCH_MINUS,
    MBX_BRANCH_PLUS,
    MBX_BRANCH_SIGNED_GE,
    MBX_BRANCH_SIGNED_LT,
    MBX_BRANCH_HALF_CARRY_SET,
    MBX_BRANCH_HALF_CARRY_CLEAR,
    MBX_BRANCH_TBIT_SET,
    MBX_BRANCH_TBIT_CLEAR,
    MBX_BRANCH_OVERFLOW_SET
  } mbx_op_t;

  typedef struct packed {
    mbx_op_t op;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [7:0] imm_val;
    logic [7:0] io_val;
    logic [2:0] bit_sel;
    logic [6:0] offset;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] z_ptr;
    logic next_two_word;
    logic [7:0] status_register;
  } mbx_req_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [15:0] product;
    logic product_we;
    logic [7:0] status_register;
    logic push_ret;
    logic [PC_W-1:0] ret_addr;
  } mbx_res_t;

endpackage

// ---- testbench/mbx_exec_asserts.sv ----
`timescale 1ns/10ps
// ************************************************************
// execution checker
// ************************************************************
module mbx_exec_asserts (
  input wire logic ref_clk_in, // core clock
  input wire logic rst_b_in, // sync reset, active low
  input wire logic start_in, // request valid
  input wire mbx_pkg::mbx_req_t req_in, // request
  input wire logic busy_out, // busy
  input wire logic done_out, // done pulse
  input wire mbx_pkg::mbx_res_t res_out // result
);
  import mbx_pkg::*;
  logic take;
  logic [15:0] tgt;
  assign take = start_in & ~busy_out & rst_b_in;
  assign tgt = req_in.pc + {{9{req_in.offset[6]}}, req_in.offset} + 16'h0001;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_mul_two;
    take && req_in.op == MBX_SIGNED_MULTIPLY |=> busy_out && !done_out
      && res_out.status_register[7:2] == $past(req_in.status_register[7:2]) ##1 done_out;
  endproperty
  a_mul_two: assert property (p_mul_two) else $error("multiply timing or flags wrong");
  property p_frac_shift;
    take && req_in.op == MBX_FRACTIONAL_MULTIPLY_UNSIGNED |=> res_out.product ==
      (({8'h00, $past(req_in.rd_val)} * {8'h00, $past(req_in.rr_val)}) << 1);
  endproperty
  a_frac_shift: assert property (p_frac_shift) else $error("fractional product wrong");
  property p_ind_jump;
    take && req_in.op == MBX_INDIRECT_JUMP |=> res_out.pc == $past(req_in.z_ptr)
      && res_out.status_register == $past(req_in.status_register) ##1 done_out;
  endproperty
  a_ind_jump: assert property (p_ind_jump) else $error("indirect jump wrong");
  property p_ind_call;
    take && req_in.op == MBX_INDIRECT_CALL |=> res_out.pc == $past(req_in.z_ptr)
      && busy_out ##1 busy_out ##1 done_out;
  endproperty
  a_ind_call: assert property (p_ind_call) else $error("indirect call wrong");
  property p_cmp_one;
    take && req_in.op == MBX_COMPARE_REGS |=> done_out && !busy_out;
  endproperty
  a_cmp_one: assert property (p_cmp_one) else $error("compare not one cycle");
  property p_skip_three;
    take && req_in.op == MBX_SKIP_REG_BIT_SET && req_in.rr_val == req_in.rd_val
      && req_in.rr_val[req_in.bit_sel] && req_in.next_two_word
      |=> res_out.pc == $past(req_in.pc) + 16'h0003 ##2 done_out;
  endproperty
  a_skip_three: assert property (p_skip_three) else $error("two word skip wrong");
  property p_io_skip;
    take && req_in.op == MBX_SKIP_IO_BIT_CLEAR && !req_in.io_val[req_in.bit_sel]
      && !req_in.next_two_word |=> res_out.pc == $past(req_in.pc) + 16'h0002
      && res_out.status_register == $past(req_in.status_register) ##1 done_out;
  endproperty
  a_io_skip: assert property (p_io_skip) else $error("io skip wrong");
  property p_beq_idle;
    take && req_in.op == MBX_BRANCH_EQUAL && !req_in.status_register[STAT_Z]
      |=> done_out && res_out.pc == $past(req_in.pc) + 16'h0001;
  endproperty
  a_beq_idle: assert property (p_beq_idle) else $error("untaken branch wrong");
  property p_sge;
    take && req_in.op == MBX_BRANCH_SIGNED_GE
      && !(req_in.status_register[STAT_N] ^ req_in.status_register[STAT_V])
      |=> res_out.pc == $past(tgt) && !done_out ##1 done_out;
  endproperty
  a_sge: assert property (p_sge) else $error("signed ge branch wrong");
  c_mul: cover property (take && req_in.op == MBX_SIGNED_MULTIPLY);
  c_ind_call: cover property (take && req_in.op == MBX_INDIRECT_CALL);
  c_skip: cover property (take && req_in.op == MBX_SKIP_IO_BIT_CLEAR);
endmodule
bind mbx_exec mbx_exec_asserts mbx_exec_asserts_i (.ref_clk_in(ref_clk_in),
  .rst_b_in(rst_b_in), .start_in(start_in), .req_in(req_in), .busy_out(busy_out),
  .done_out(done_out), .res_out(res_out));

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import mbx_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic start_in = 1'b0;
  mbx_req_t req_in = '0;
  logic busy_out, done_out;
  mbx_res_t res_out;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'h4052;
  mbx_exec mbx_exec_i (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .start_in(start_in),
    .req_in(req_in), .busy_out(busy_out), .done_out(done_out), .res_out(res_out));
  always #2 ref_clk_in = ~ref_clk_in;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ************************************************************
  // expected pc, cycles, flags and product
  // ************************************************************
  function automatic void model(input mbx_req_t r, output logic [15:0] pc,
    output logic [15:0] cyc,
    output logic [7:0] st, output logic [15:0] prod);
    logic [7:0] f, b, d;
    logic br, sk, ci, c, h;
    f = r.status_register;
    st = f;
    prod = 16'h0000;
    pc = r.pc + 16'h0001;
    cyc = 16'h0001;
    br = 1'b0;
    sk = 1'b0;
    case (r.op)
      MBX_SIGNED_MULTIPLY: prod = 16'($signed(r.rd_val) * $signed(r.rr_val));
      MBX_SIGNED_UNSIGNED_MULTIPLY: prod = 16'($signed(r.rd_val) * $signed({1'b0, r.rr_val}));
      MBX_FRACTIONAL_MULTIPLY_UNSIGNED: prod = {8'h00, r.rd_val} * {8'h00, r.rr_val};
      MBX_FRACTIONAL_MULTIPLY_SIGNED: prod = 16'($signed(r.rd_val) * $signed(r.rr_val));
      MBX_FRACTIONAL_MULTIPLY_MIXED: prod = 16'($signed(r.rd_val) * $signed({1'b0, r.rr_val}));
      MBX_INDIRECT_JUMP, MBX_INDIRECT_CALL: pc = r.z_ptr;
      MBX_COMPARE_SKIP_EQUAL: sk = r.rd_val == r.rr_val;
      MBX_SKIP_REG_BIT_CLEAR: sk = !r.rr_val[r.bit_sel];
      MBX_SKIP_REG_BIT_SET: sk = r.rr_val[r.bit_sel];
      MBX_SKIP_IO_BIT_CLEAR: sk = !r.io_val[r.bit_sel];
      MBX_SKIP_IO_BIT_SET: sk = r.io_val[r.bit_sel];
      MBX_BRANCH_FLAG_SET: br = f[r.bit_sel];
      MBX_BRANCH_FLAG_CLEAR: br = !f[r.bit_sel];
      MBX_BRANCH_EQUAL: br = f[STAT_Z];
      MBX_BRANCH_NOT_EQUAL: br = !f[STAT_Z];
      MBX_BRANCH_CARRY_SET, MBX_BRANCH_LOWER: br = f[STAT_C];
      MBX_BRANCH_CARRY_CLEAR, MBX_BRANCH_SAME_HIGHER: br = !f[STAT_C];
      MBX_BRANCH_MINUS: br = f[STAT_N];
      MBX_BRANCH_PLUS: br = !f[STAT_N];
      MBX_BRANCH_SIGNED_GE: br = !(f[STAT_N] ^ f[STAT_V]);
      MBX_BRANCH_SIGNED_LT: br = f[STAT_N] ^ f[STAT_V];
      MBX_BRANCH_HALF_CARRY_SET: br = f[STAT_H];
      MBX_BRANCH_HALF_CARRY_CLEAR: br = !f[STAT_H];
      MBX_BRANCH_TBIT_SET: br = f[STAT_T];
      MBX_BRANCH_TBIT_CLEAR: br = !f[STAT_T];
      MBX_BRANCH_OVERFLOW_SET: br = f[STAT_V];
      default: ;
    endcase
    if (r.op <= MBX_FRACTIONAL_MULTIPLY_MIXED)
    begin
      st[STAT_C] = prod[15];
      if (r.op >= MBX_FRACTIONAL_MULTIPLY_UNSIGNED)
        prod = prod << 1;
      st[STAT_Z] = prod == 16'h0000;
      cyc = 16'h0002;
    end
    if (r.op == MBX_INDIRECT_JUMP)
      cyc = 16'h0002;
    if (r.op == MBX_INDIRECT_CALL)
      cyc = 16'h0003;
    if (sk)
    begin
      cyc = r.next_two_word ? 16'h0003 : 16'h0002;
      pc = r.pc + cyc;
    end
    if (br)
    begin
      pc = r.pc + {{9{r.offset[6]}}, r.offset} + 16'h0001;
      cyc = 16'h0002;
    end
    if (r.op >= MBX_COMPARE_REGS && r.op <= MBX_COMPARE_IMMEDIATE)
    begin
      b = r.op == MBX_COMPARE_IMMEDIATE ? r.imm_val : r.rr_val;
      ci = r.op == MBX_COMPARE_WITH_CARRY ? f[STAT_C] : 1'b0;
      {c, d} = {1'b0, r.rd_val} - {1'b0, b} - {8'h00, ci};
      h = 1'({1'b0, r.rd_val[3:0]} - {1'b0, b[3:0]} - {4'h0, ci} >> 4);
      st[STAT_C] = c;
      st[STAT_H] = h;
      st[STAT_N] = d[7];
      st[STAT_V] = (r.rd_val[7] ^ b[7]) & (r.rd_val[7] ^ d[7]);
      st[STAT_S] = st[STAT_N] ^ st[STAT_V];
      // carry form chains: zero only survives if the earlier byte was zero too
      st[STAT_Z] = d == 8'h00 && (r.op != MBX_COMPARE_WITH_CARRY || f[STAT_Z]);
    end
  endfunction
  // ************************************************************
  // main sequence: every code twice with corner fields, then random
  // ************************************************************
  initial
  begin
    logic [95:0] raw;
    mbx_req_t r;
    logic [15:0] pc, cyc, prod, n;
    logic [7:0] st;
    logic mul;
    repeat (12) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 400; i++)
    begin
      raw = {$random(seed), $random(seed), $random(seed)};
      r = raw[87:0];
      if (i < 64)
      begin
        r.op = mbx_op_t'(i[4:0]);
        r.offset = i[5] ? 7'h40 : 7'h3f;
        r.next_two_word = i[5];
        r.rd_val = i[0] ? 8'h80 : r.rd_val;
        r.rr_val = i[0] ? 8'h80 : r.rr_val;
      end
      // skip-on-register tests one operand; keep both equal
      if (r.op == MBX_SKIP_REG_BIT_CLEAR || r.op == MBX_SKIP_REG_BIT_SET)
        r.rd_val = r.rr_val;
      model(r, pc, cyc, st, prod);
      @(posedge ref_clk_in);
      start_in <= 1'b1;
      req_in <= r;
      @(posedge ref_clk_in);
      start_in <= 1'b0;
      #1;
      n = 16'h0001;
      while (done_out !== 1'b1 && n < 16'h0008)
      begin
        @(posedge ref_clk_in);
        #1;
        n++;
      end
      chk(n, cyc);
      chk(res_out.pc, pc);
      chk({8'h00, res_out.status_register}, {8'h00, st});
      mul = r.op <= MBX_FRACTIONAL_MULTIPLY_MIXED;
      chk({15'h0000, res_out.product_we}, {15'h0000, mul});
      chk({15'h0000, res_out.push_ret}, {15'h0000, r.op == MBX_INDIRECT_CALL});
      if (r.op <= MBX_FRACTIONAL_MULTIPLY_MIXED)
        chk(res_out.product, prod);
      if (r.op == MBX_INDIRECT_CALL)
        chk(res_out.ret_addr, r.pc + 16'h0001);
    end
    conclude();
  end
  initial
  begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule
